// ### hw/mft_count_pkg.sv
// Purpose: constants and types for the multifunction timer counting block
// Assumes: APB slave, 32-bit data, pclk at 25 MHz
// Notes: register offsets are byte addresses
package mft_count_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_INCTL = 8'h08;
  localparam logic [7:0] OFF_PRESC = 8'h0C;
  localparam logic [7:0] OFF_REG0 = 8'h10;
  localparam logic [7:0] OFF_REG1 = 8'h14;
  localparam logic [7:0] OFF_CMP0 = 8'h18;
  localparam logic [7:0] OFF_COUNT = 8'h1C;
  localparam logic [7:0] OFF_FLAGS = 8'h20;
  // Control register fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_CLEAR = 1;
  localparam int CTL_CLEAR_ON_CAPTURE_ENABLE = 2;
  localparam int CTL_CLEAR_ON_COMPARE_ENABLE = 3;
  localparam int CTL_UDC = 4;
  localparam int CTL_DIRECTION_STATUS_BIT = 5;
  // Mode register fields
  localparam int MODE_ONESHOT = 0;
  localparam int MODE_RM0 = 1;
  localparam int MODE_RM1 = 2;
  localparam int MODE_BM = 3;
  localparam int MODE_ECK = 4;
  localparam int MODE_REN = 5;
  // Input control fields
  localparam int IC_FUNC_LSB = 0;
  localparam int IC_B_LSB = 4;
  localparam int IC_A_LSB = 6;
  // Flag register fields
  localparam int FLG_CP0 = 0;
  localparam int FLG_CP1 = 1;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_MIN = 16'h0000;
  localparam logic [1:0] TICK_DIV = 2'h2;
  localparam logic [31:0] APB_ZERO = 32'h0000_0000;
  typedef enum logic [3:0] {
    FN_NONE = 4'b0000, FN_B_TRIG = 4'b0001, FN_A_GATE = 4'b0010,
    FN_AG_BT = 4'b0011, FN_B_CLK = 4'b0100, FN_A_TRIG = 4'b0101,
    FN_AG_BC = 4'b0110, FN_AT_BT = 4'b0111, FN_CLK_UD = 4'b1000,
    FN_AUD_BC = 4'b1001, FN_TRIG_UD = 4'b1010, FN_AUD = 4'b1011,
    FN_AUTODISC = 4'b1100, FN_AT_BC = 4'b1101, FN_AC_BT = 4'b1110,
    FN_AT_BG = 4'b1111
  } input_function_code_t;
  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic prev_a;
    logic prev_b;
    logic [1:0] div3;
    logic [7:0] presc_cnt;
    logic [15:0] counter;
    logic dir_up;
    logic trig_dir;
    logic bi_sel;
    logic stopped;
    logic [7:0] timer_control_reg;
    logic [7:0] timer_mode_reg;
    logic [7:0] input_control_reg;
    logic [7:0] presc_reg;
    logic [15:0] capture_load_reg_zero;
    logic [15:0] capture_load_reg_one;
    logic [15:0] compare_reg_zero;
    logic [31:0] prdata;
    logic presc_out;
  } state_t;
endpackage : mft_count_pkg

// ### hw/mft_count.sv
// Purpose: counting-mode core of a 16-bit up/down multifunction timer
// Assumes: ext inputs asynchronous, synchronised here; APB zero-wait
// Notes: chain_presc_in comes from a partner timer's presc_tick
//
// Register access over APB and the address map were left to the implementer.
module mft_count (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire logic ext_input_a,
  input wire logic ext_input_b,
  // Chaining
  input wire logic chain_presc_in,
  output logic presc_tick,
  // Status
  output logic [15:0] count_value,
  output logic direction_status_bit
);
  import mft_count_pkg::*;

  state_t r;
  state_t n;

  function automatic logic edge_hit(input logic [1:0] sel, input logic prv, input logic cur);
    edge_hit = (sel[0] && !prv && cur) || (sel[1] && prv && !cur);
  endfunction : edge_hit

  logic wr;
  logic rd;
  logic ev_a;
  logic ev_b;
  logic rise_b;
  logic fall_b;
  logic bm;
  logic rm0;
  logic rm1;
  logic cp0;
  logic cp1;
  input_function_code_t fn;
  logic a_trig;
  logic b_trig;
  logic a_gate;
  logic b_gate;
  logic ext_clk;
  logic ext_clk_sel;
  logic presc_src;
  logic gate_ok;
  logic step;
  logic step_up;
  logic clear;
  logic eoc;
  logic load0;
  logic cap0;
  logic cap1;
  logic free_run;
  logic [15:0] reload_val;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = r.prdata;
  assign presc_tick = r.presc_out;
  assign count_value = r.counter;
  assign direction_status_bit = r.dir_up;

  always_comb begin
    n = r;
    // Only stage two of each synchroniser is looked at
    n.sync_a = {r.sync_a[0], ext_input_a};
    n.sync_b = {r.sync_b[0], ext_input_b};
    n.prev_a = r.sync_a[1];
    n.prev_b = r.sync_b[1];
    bm = r.timer_mode_reg[MODE_BM];
    rm0 = r.timer_mode_reg[MODE_RM0];
    rm1 = r.timer_mode_reg[MODE_RM1];
    fn = input_function_code_t'(r.input_control_reg[IC_FUNC_LSB +: 4]);
    ev_a = edge_hit(r.input_control_reg[IC_A_LSB +: 2], r.prev_a, r.sync_a[1]);
    ev_b = edge_hit(r.input_control_reg[IC_B_LSB +: 2], r.prev_b, r.sync_b[1]);
    rise_b = !r.prev_b && r.sync_b[1];
    fall_b = r.prev_b && !r.sync_b[1];
    cp0 = wr && paddr == OFF_FLAGS && pwdata[FLG_CP0];
    cp1 = wr && paddr == OFF_FLAGS && pwdata[FLG_CP1];
    // Function decode
    a_trig = 1'b0;
    b_trig = 1'b0;
    a_gate = 1'b0;
    b_gate = 1'b0;
    ext_clk = 1'b0;
    ext_clk_sel = 1'b0;
    case (fn)
      FN_NONE: ;
      FN_B_TRIG: b_trig = ev_b;
      FN_A_GATE: a_gate = 1'b1;
      FN_AG_BT: begin
        a_gate = 1'b1;
        b_trig = ev_b;
      end
      FN_B_CLK: begin
        ext_clk_sel = 1'b1;
        ext_clk = ev_b;
      end
      FN_A_TRIG: a_trig = ev_a;
      FN_AG_BC: begin
        a_gate = 1'b1;
        ext_clk_sel = 1'b1;
        ext_clk = ev_b;
      end
      FN_AT_BT: begin
        a_trig = ev_a;
        b_trig = ev_b;
      end
      FN_CLK_UD: ;
      FN_AUD_BC: begin
        ext_clk_sel = 1'b1;
        ext_clk = ev_b;
      end
      FN_TRIG_UD: ;
      FN_AUD: ;
      FN_AUTODISC: ;
      FN_AT_BC: begin
        a_trig = ev_a;
        ext_clk_sel = 1'b1;
        ext_clk = ev_b;
      end
      FN_AC_BT: begin
        ext_clk_sel = 1'b1;
        ext_clk = ev_a;
        b_trig = ev_b;
      end
      FN_AT_BG: begin
        a_trig = ev_a;
        b_gate = 1'b1;
      end
      default: ;
    endcase
    // Gate active low; B trigger and B gate are off in bivalue mode, B clock and up/down edges still act
    if (bm) begin
      b_trig = 1'b0;
      b_gate = 1'b0;
    end
    gate_ok = !(a_gate && r.sync_a[1]) && !(b_gate && r.sync_b[1]);
    // Prescaler: system clock third, external or chained
    n.div3 = (r.div3 == TICK_DIV) ? 2'h0 : r.div3 + 2'h1;
    if (r.timer_mode_reg[MODE_ECK])
      presc_src = chain_presc_in;
    else if (ext_clk_sel)
      presc_src = ext_clk;
    else
      presc_src = (r.div3 == TICK_DIV);
    n.presc_out = 1'b0;
    if (r.timer_control_reg[CTL_ENABLE] && gate_ok && presc_src) begin
      if (r.presc_cnt == 8'h00) begin
        n.presc_cnt = r.presc_reg;
        n.presc_out = 1'b1;
      end else begin
        n.presc_cnt = r.presc_cnt - 8'h01;
      end
    end
    // Direction and step
    step = r.presc_out && !r.stopped;
    step_up = r.timer_control_reg[CTL_UDC];
    case (fn)
      FN_CLK_UD: begin
        step = (ev_a || ev_b) && r.timer_control_reg[CTL_ENABLE];
        step_up = !ev_b; // B has priority
      end
      FN_AUD_BC, FN_AUD: step_up = r.sync_a[1];
      FN_TRIG_UD: begin
        if (ev_b)
          n.trig_dir = 1'b0;
        else if (ev_a)
          n.trig_dir = 1'b1;
        step_up = n.trig_dir;
      end
      FN_AUTODISC: begin
        // B edge while A low decides the sign; A high means no step
        step = (rise_b || fall_b) && !r.sync_a[1] && r.timer_control_reg[CTL_ENABLE];
        // Status keeps the sign of the last step between pulses
        step_up = step ? rise_b : r.dir_up;
      end
      default: ;
    endcase
    n.dir_up = step_up;
    // Trigger routing
    load0 = 1'b0;
    cap0 = 1'b0;
    cap1 = 1'b0;
    if (a_trig || cp0) begin
      if (rm0)
        cap0 = 1'b1;
      else if (!(r.timer_mode_reg[MODE_ONESHOT] && !r.timer_mode_reg[MODE_REN] && !r.stopped))
        load0 = 1'b1;
    end
    if (b_trig || cp1)
      cap1 = 1'b1;
    // Bicapture steers zero captures alternately
    if (bm && rm0 && cap0) begin
      if (r.bi_sel)
        n.capture_load_reg_one = r.counter;
      else
        n.capture_load_reg_zero = r.counter;
      n.bi_sel = !r.bi_sel;
    end else begin
      if (cap0)
        n.capture_load_reg_zero = r.counter;
      if (cap1 && (rm1 || bm))
        n.capture_load_reg_one = r.counter;
    end
    // Counting
    free_run = (bm && rm0) || (rm0 && !r.timer_mode_reg[MODE_ONESHOT]);
    eoc = step && (step_up ? r.counter == CNT_MAX : r.counter == CNT_MIN);
    reload_val = (bm && !rm0 && r.bi_sel) ? r.capture_load_reg_one : r.capture_load_reg_zero;
    if (step) begin
      n.counter = step_up ? r.counter + 16'h0001 : r.counter - 16'h0001;
      if (eoc && !free_run) begin
        if (r.timer_mode_reg[MODE_ONESHOT]) begin
          n.stopped = 1'b1;
        end else begin
          n.counter = reload_val;
          if (bm && !rm0)
            n.bi_sel = !r.bi_sel;
        end
      end
    end
    if (load0) begin
      n.counter = r.capture_load_reg_zero;
      n.stopped = 1'b0;
      if (bm && !rm0)
        n.bi_sel = 1'b1;
    end
    if (!bm)
      n.bi_sel = 1'b0;
    // Clear has last word over step and load
    clear = (wr && paddr == OFF_CTRL && pwdata[CTL_CLEAR])
      || (r.timer_control_reg[CTL_CLEAR_ON_CAPTURE_ENABLE] && cap0 && !(bm && r.bi_sel))
      || (r.timer_control_reg[CTL_CLEAR_ON_COMPARE_ENABLE] && step && r.counter == r.compare_reg_zero);
    if (clear) begin
      n.counter = step_up ? CNT_MIN : CNT_MAX;
      n.presc_cnt = r.presc_reg;
    end
    // Monitor copy
    if (!rm1 && !bm)
      n.capture_load_reg_one = n.counter;
    // Register writes
    if (wr) begin
      case (paddr)
        OFF_CTRL: n.timer_control_reg = pwdata[7:0] & 8'h1D;
        OFF_MODE: n.timer_mode_reg = pwdata[7:0];
        OFF_INCTL: n.input_control_reg = pwdata[7:0];
        OFF_PRESC: n.presc_reg = pwdata[7:0];
        OFF_REG0: n.capture_load_reg_zero = pwdata[15:0];
        OFF_REG1: n.capture_load_reg_one = pwdata[15:0];
        OFF_CMP0: n.compare_reg_zero = pwdata[15:0];
        default: ;
      endcase
    end
    // Read data captured in setup, stands through access
    if (rd) begin
      case (paddr)
        OFF_CTRL: n.prdata = {24'h00_0000, r.timer_control_reg[7:6], r.dir_up,
          r.timer_control_reg[4:0]};
        OFF_MODE: n.prdata = {24'h00_0000, r.timer_mode_reg};
        OFF_INCTL: n.prdata = {24'h00_0000, r.input_control_reg};
        OFF_PRESC: n.prdata = {24'h00_0000, r.presc_reg};
        OFF_REG0: n.prdata = {16'h0000, r.capture_load_reg_zero};
        OFF_REG1: n.prdata = {16'h0000, r.capture_load_reg_one};
        OFF_CMP0: n.prdata = {16'h0000, r.compare_reg_zero};
        OFF_COUNT: n.prdata = {16'h0000, r.counter};
        default: n.prdata = APB_ZERO;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end
endmodule : mft_count

// ### tb/mft_count_checker.sv
// Purpose: port checks for mft_count
// Assumes: one clock, async low reset
// Notes: bound to every mft_count
module mft_count_checker
  import mft_count_pkg::*;
(
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Counter
  input wire logic presc_tick,
  input wire logic [15:0] count_value,
  input wire logic direction_status_bit
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_rd;
    psel && !penable && !pwrite;
  endsequence
  sequence s_clr;
    psel && penable && pwrite && paddr == OFF_CTRL && pwdata[CTL_CLEAR];
  endsequence
  property p_ok;
    pready && !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("bus answer");
  property p_clr;
    s_clr |=> count_value == (direction_status_bit ? CNT_MIN : CNT_MAX);
  endproperty
  a_clr: assert property (p_clr) else $error("clear value");
  property p_clr_step;
    s_clr ##0 presc_tick |=> count_value inside {CNT_MIN, CNT_MAX};
  endproperty
  a_clr_step: assert property (p_clr_step) else $error("step beat clear");
  property p_gap;
    presc_tick |=> !presc_tick [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("tick too fast");
  property p_cnt_rd;
    s_rd ##0 paddr == OFF_COUNT |=> prdata == {16'h0000, $past(count_value)};
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("count read");
  property p_unmapped;
    s_rd ##0 (paddr > OFF_FLAGS || paddr[1:0] != 2'b00) |=> prdata == APB_ZERO;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst;
    $rose(presetn) |-> count_value == CNT_MIN && prdata == APB_ZERO;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values");
endmodule : mft_count_checker

bind mft_count mft_count_checker i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .presc_tick(presc_tick), .count_value(count_value),
  .direction_status_bit(direction_status_bit)
);

// ### tb/mft_pin_source.sv
// Purpose: far-side model of the two timer input pins
// Assumes: bench requests levels on want_a and want_b
// Notes: a request waits until the pin may legally move
module mft_pin_source (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests
  input wire logic want_a,
  input wire logic want_b,
  // Pins
  output logic ext_input_a,
  output logic ext_input_b
);
  logic [2:0] age_a;
  logic [2:0] age_b;
  logic move_a;
  logic move_b;
  // Six clocks covers both edge and gate minimums
  assign move_a = want_a != ext_input_a && age_a == 3'h6;
  // B never shares a clock with an A edge
  assign move_b = want_b != ext_input_b && age_b == 3'h6 && !move_a;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_input_a <= 1'b0;
      ext_input_b <= 1'b0;
      age_a <= 3'h0;
      age_b <= 3'h0;
    end else begin
      ext_input_a <= move_a ? want_a : ext_input_a;
      ext_input_b <= move_b ? want_b : ext_input_b;
      age_a <= move_a ? 3'h0 : age_a + {2'h0, age_a != 3'h6};
      age_b <= move_b ? 3'h0 : age_b + {2'h0, age_b != 3'h6};
    end
  end
endmodule : mft_pin_source

// ### tb/multifunction_timer_count_modes_tb_top.sv
// Purpose: self-checking bench for the timer counting block
// Assumes: pclk 25 MHz, reset low four cycles
// Notes: pulse counts random from a fixed seed
module multifunction_timer_count_modes_tb_top;
  import mft_count_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, chain_presc_in, want_a, want_b;
  logic ext_input_a, ext_input_b, pready, pslverr, presc_tick, direction_status_bit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] count_value;
  logic [23:0] plan [7];
  int failures, n_compared, seed, cycles, n;
  mft_count i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_input_a(ext_input_a), .ext_input_b(ext_input_b), .chain_presc_in(chain_presc_in),
    .presc_tick(presc_tick), .count_value(count_value),
    .direction_status_bit(direction_status_bit)
  );
  mft_pin_source i_src (
    .pclk(pclk), .presetn(presetn), .want_a(want_a), .want_b(want_b),
    .ext_input_a(ext_input_a), .ext_input_b(ext_input_b)
  );
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd[15:0], e);
  endtask : rchk
  task automatic wait_for(input logic [15:0] v, input int lim);
    int k;
    for (k = 0; k < lim && count_value !== v; k++) @(posedge pclk);
    check(16'(k < lim), 16'h0001);
  endtask : wait_for
  // Target 0 pin A, 1 pin B, 2 chain, 3 gate held, 4 B leads an overlapping A
  task automatic pulse(input int t);
    chain_presc_in <= t == 2;
    if (t == 0) want_a <= 1'b1;
    if (t == 1 || t == 4) want_b <= 1'b1;
    @(posedge pclk);
    chain_presc_in <= 1'b0;
    repeat (8) @(posedge pclk);
    if (t == 4) want_a <= 1'b1;
    if (t == 4) repeat (8) @(posedge pclk);
    if (t < 2) want_a <= 1'b0;
    want_b <= 1'b0;
    repeat (8) @(posedge pclk);
    // B falls while A is high, so only its rise counts
    if (t == 4) want_a <= 1'b0;
    if (t == 4) repeat (8) @(posedge pclk);
  endtask : pulse
  function automatic logic [15:0] exp_delta(input logic [7:0] ic, input int t, input int k);
    if (t == 3) return 16'h0000;
    if (t == 0 && ic[7:6] == 2'b11) k = 2 * k;
    if (ic[3:0] == FN_CLK_UD && t == 1) k = -k;
    return 16'(k);
  endfunction : exp_delta
  initial begin
    seed = 94;
    {psel, penable, pwrite, chain_presc_in, want_a, want_b} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    plan = '{24'h00_4800, 24'h00_C800, 24'h00_1C04, 24'h00_1401,
             24'h10_0002, 24'h00_0203, 24'h02_2801};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Clear takes the direction in force before the same write
    wr(OFF_CTRL, 32'h0000_0010);
    wr(OFF_CTRL, 32'h0000_0012);
    check(count_value, CNT_MIN);
    check(16'(direction_status_bit), 16'h0001);
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0002);
    check(count_value, CNT_MAX);
    rchk(OFF_REG1, CNT_MAX);
    rchk(8'h24, 16'h0000);
    wr(OFF_MODE, 32'h0000_0020);
    wr(OFF_REG0, 32'h0000_FFFD);
    wr(OFF_FLAGS, 32'h0000_0001);
    check(count_value, 16'hFFFD);
    wr(OFF_MODE, 32'h0000_0002);
    wr(OFF_CTRL, 32'h0000_0011);
    wait_for(CNT_MIN, 40);
    wait_for(16'h0001, 5);
    wr(OFF_CTRL, 32'h0000_0015);
    repeat (20) @(posedge pclk);
    wr(OFF_FLAGS, 32'h0000_0001);
    wait_for(CNT_MIN, 2);
    wr(OFF_CTRL, 32'h0000_0010);
    wr(OFF_MODE, 32'h0000_0028);
    wr(OFF_REG0, 32'h0000_FFF0);
    wr(OFF_REG1, 32'h0000_FFE0);
    wr(OFF_FLAGS, 32'h0000_0001);
    check(count_value, 16'hFFF0);
    wr(OFF_CTRL, 32'h0000_0011);
    wait_for(CNT_MAX, 80);
    wait_for(16'hFFE0, 5);
    wait_for(CNT_MAX, 140);
    wait_for(16'hFFF0, 5);
    wr(OFF_CTRL, 32'h0000_0002);
    wr(OFF_MODE, 32'h0000_0000);
    wr(OFF_MODE, 32'h0000_000A);
    wr(OFF_FLAGS, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0002);
    wr(OFF_FLAGS, 32'h0000_0001);
    rchk(OFF_REG0, CNT_MIN);
    rchk(OFF_REG1, CNT_MAX);
    wr(OFF_PRESC, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      n = 1 + ($unsigned($random(seed)) % 4);
      want_a <= plan[i][2:0] == 3'h3;
      wr(OFF_CTRL, 32'h0000_0010);
      wr(OFF_MODE, {24'h00_0000, plan[i][23:16]});
      wr(OFF_INCTL, {24'h00_0000, plan[i][15:8]});
      repeat (10) @(posedge pclk);
      wr(OFF_CTRL, 32'h0000_0013);
      repeat (n) pulse(plan[i][2:0]);
      repeat (8) @(posedge pclk);
      check(count_value, exp_delta(plan[i][15:8], plan[i][2:0], n));
    end
    rchk(OFF_COUNT, exp_delta(plan[6][15:8], plan[6][2:0], n));
    give_verdict();
  end
endmodule : multifunction_timer_count_modes_tb_top
